/* File: afc_cfg.svh */
// Offsets, field positions and reset values of the fault configuration block
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH

// Register indices; byte address is four times the index
`define AFC_IDX_ALARM_CFG   8'h1c
`define AFC_IDX_FILT_CH0    8'h1d
`define AFC_IDX_FILT_CH1    8'h1e
`define AFC_IDX_IRQ_STAT    8'h30
`define AFC_IDX_IRQ_CLR     8'h31
`define AFC_IDX_IRQ_EN      8'h32
`define AFC_IDX_FAULT_RAW   8'h33

// Byte address bits that carry the index
`define AFC_ADDR_IDX_MSB    9
`define AFC_ADDR_IDX_LSB    2

// Fault configuration fields
`define AFC_BIT_CRC_MASK    7
`define AFC_BIT_REF_MASK    6
`define AFC_BIT_NEG_MASK    5
`define AFC_BIT_OT_MASK     4
`define AFC_BIT_WARN_MASK   3
`define AFC_BIT_BG_CRC_EN   2
`define AFC_BIT_TSD_EN      1
`define AFC_BIT_OPEN_DRAIN  0
`define AFC_MASK_MSB        7
`define AFC_MASK_LSB        3
`define AFC_ALARM_CFG_RST   8'h06

// Filter select field
`define AFC_FILT_MSB        3
`define AFC_FILT_RST        4'h0
`define AFC_FILT_60R        4'h0
`define AFC_FILT_5K6        4'h5
`define AFC_FILT_11K2       4'h6
`define AFC_FILT_22K2       4'h7
`define AFC_FILT_44K4       4'h8
`define AFC_FILT_104K       4'h9

// Interrupt registers
`define AFC_IRQ_RST         5'h00

`endif

/* File: afc_pkg.sv */
// Types shared by the fault configuration block
`default_nettype none
package afc_pkg;

    // One bit per fault source, ordered as the mask bits 7 down to 3
    typedef struct packed {
        logic crc_mismatch;
        logic ref_resistor_fault;
        logic neg_monitor_ch0;
        logic over_temp_fault;
        logic over_temp_warning;
    } afc_fault_type;

    // Fault pin drive as seen at the pad
    typedef struct packed {
        logic value;
        logic oe_n;
    } afc_pin_type;

    typedef enum logic [1:0] {
        AFC_BUS_IDLE   = 2'b00,
        AFC_BUS_ACCESS = 2'b01,
        AFC_BUS_DONE   = 2'b10
    } afc_bus_state_type;

endpackage
`default_nettype wire

/* File: afc_top.sv */
// Fault pin configuration and output filter select registers over APB
`timescale 1ns/1ns
`default_nettype none
`include "afc_cfg.svh"

module afc_top
    import afc_pkg::*;
#(
    parameter int NUM_FILT_CH = 2,
    parameter int FILT_W      = 4
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire afc_fault_type        fault_src,
    output afc_pin_type               fault_pin_n,
    output logic                      bg_crc_enable,
    output logic                      thermal_shutdown,
    output logic [FILT_W-1:0]         filter_res_sel_ch0,
    output logic [FILT_W-1:0]         filter_res_sel_ch1,
    output logic [NUM_FILT_CH-1:0]    filter_code_reserved,
    output logic                      irq
);

    localparam int NSRC = $bits(afc_fault_type);

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic afc_hit(input logic [7:0] idx,
                                     input logic [7:0] want);
        afc_hit = (idx == want);
    endfunction

    function automatic logic afc_filt_valid(input logic [FILT_W-1:0] c);
        afc_filt_valid = (c == FILT_W'(`AFC_FILT_60R))  ||
                         (c == FILT_W'(`AFC_FILT_5K6))  ||
                         (c == FILT_W'(`AFC_FILT_11K2)) ||
                         (c == FILT_W'(`AFC_FILT_22K2)) ||
                         (c == FILT_W'(`AFC_FILT_44K4)) ||
                         (c == FILT_W'(`AFC_FILT_104K));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    afc_bus_state_type bus_state_ff;
    afc_bus_state_type nxt_bus_state;
    logic [31:0]       prdata_ff;
    logic [31:0]       nxt_prdata;
    logic              pslverr_ff;
    logic              nxt_pslverr;

    logic [7:0]  alarm_cfg_ff;
    logic [FILT_W-1:0] filt_ff [NUM_FILT_CH];
    logic [NSRC-1:0]   irq_stat_ff;
    logic [NSRC-1:0]   irq_en_ff;
    logic [NSRC-1:0]   src_prev_ff;
    afc_pin_type       pin_ff;
    logic              tsd_ff;

    wire logic [7:0] reg_idx =
        paddr[`AFC_ADDR_IDX_MSB:`AFC_ADDR_IDX_LSB];
    wire logic addr_hi_zero = (paddr[31:`AFC_ADDR_IDX_MSB+1] == '0) &&
                              (paddr[`AFC_ADDR_IDX_LSB-1:0] == '0);
    wire logic hit_cfg   = addr_hi_zero &&
                           afc_hit(reg_idx, `AFC_IDX_ALARM_CFG);
    wire logic hit_f0    = addr_hi_zero &&
                           afc_hit(reg_idx, `AFC_IDX_FILT_CH0);
    wire logic hit_f1    = addr_hi_zero &&
                           afc_hit(reg_idx, `AFC_IDX_FILT_CH1);
    wire logic hit_stat  = addr_hi_zero &&
                           afc_hit(reg_idx, `AFC_IDX_IRQ_STAT);
    wire logic hit_clr   = addr_hi_zero &&
                           afc_hit(reg_idx, `AFC_IDX_IRQ_CLR);
    wire logic hit_en    = addr_hi_zero &&
                           afc_hit(reg_idx, `AFC_IDX_IRQ_EN);
    wire logic hit_raw   = addr_hi_zero &&
                           afc_hit(reg_idx, `AFC_IDX_FAULT_RAW);
    wire logic hit_any   = hit_cfg | hit_f0 | hit_f1 | hit_stat |
                           hit_clr | hit_en | hit_raw;
    // Status and raw fault registers are read-only, clear is write-only
    wire logic bad_dir   = (pwrite && (hit_stat || hit_raw)) ||
                           (!pwrite && hit_clr);

    wire logic setup_ph  = psel && !penable;
    wire logic commit    = psel && penable && pready;
    wire logic wr_ok     = commit && pwrite && !pslverr_ff && pstrb[0];

    wire logic wr_cfg    = wr_ok && hit_cfg;
    wire logic wr_clr    = wr_ok && hit_clr;
    wire logic wr_en     = wr_ok && hit_en;
    // Filter write strobes, one per channel, driven in g_filt
    logic [NUM_FILT_CH-1:0] wr_filt;

    ////////////////////////////////////////////////////////////////////////
    // Fault gating

    wire logic [NSRC-1:0] src_vec  = fault_src;
    wire logic [NSRC-1:0] src_mask =
        alarm_cfg_ff[`AFC_MASK_MSB:`AFC_MASK_LSB];
    // Masks only gate the pin; detection and status stay live
    wire afc_fault_type src_unmasked =
        afc_fault_type'(src_vec & ~src_mask);
    wire logic crc_pin   = src_unmasked.crc_mismatch;
    wire logic ref_pin   = src_unmasked.ref_resistor_fault;
    wire logic neg_pin   = src_unmasked.neg_monitor_ch0;
    wire logic ot_pin    = src_unmasked.over_temp_fault;
    wire logic warn_pin  = src_unmasked.over_temp_warning;
    wire logic alarm_act = crc_pin | ref_pin | neg_pin | ot_pin | warn_pin;

    wire logic open_drain = alarm_cfg_ff[`AFC_BIT_OPEN_DRAIN];
    afc_pin_type nxt_pin;
    // Open-drain pulls low only on alarm, push-pull always drives
    assign nxt_pin.value = open_drain ? 1'b0 : ~alarm_act;
    assign nxt_pin.oe_n  = open_drain ? ~alarm_act : 1'b0;

    // Shutdown follows the raw over_temp_fault level when enabled; the mask does not gate it
    wire logic nxt_tsd = alarm_cfg_ff[`AFC_BIT_TSD_EN] &&
                         fault_src.over_temp_fault;

    // Sticky status: rising edge of any source, set beats clear
    wire logic [NSRC-1:0] src_rise = src_vec & ~src_prev_ff;
    wire logic [NSRC-1:0] clr_bits =
        wr_clr ? pwdata[NSRC-1:0] : '0;
    wire logic [NSRC-1:0] nxt_irq_stat =
        (irq_stat_ff & ~clr_bits) | src_rise;
    wire logic [NSRC-1:0] nxt_irq_en =
        wr_en ? pwdata[NSRC-1:0] : irq_en_ff;
    wire logic [7:0] nxt_alarm_cfg =
        wr_cfg ? pwdata[7:0] : alarm_cfg_ff;

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (hit_cfg) begin
            nxt_prdata[7:0] = alarm_cfg_ff;
        end
        if (hit_f0) begin
            nxt_prdata[FILT_W-1:0] = filt_ff[0];
        end
        if (hit_f1) begin
            nxt_prdata[FILT_W-1:0] = filt_ff[1];
        end
        if (hit_stat) begin
            nxt_prdata[NSRC-1:0] = irq_stat_ff;
        end
        if (hit_en) begin
            nxt_prdata[NSRC-1:0] = irq_en_ff;
        end
        if (hit_raw) begin
            nxt_prdata[NSRC-1:0] = src_vec;
        end
        if (!hit_any || bad_dir || pwrite) begin
            nxt_prdata = 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB sequencer: setup cycle latches the answer, access completes

    always_comb begin
        nxt_bus_state = bus_state_ff;
        nxt_pslverr   = pslverr_ff;
        case (bus_state_ff)
            AFC_BUS_IDLE: begin
                if (setup_ph) begin
                    nxt_bus_state = AFC_BUS_ACCESS;
                    nxt_pslverr   = !hit_any || bad_dir;
                end
            end
            AFC_BUS_ACCESS: begin
                if (commit) begin
                    nxt_bus_state = AFC_BUS_DONE;
                end
            end
            AFC_BUS_DONE: begin
                nxt_pslverr = 1'b0;
                if (setup_ph) begin
                    nxt_bus_state = AFC_BUS_ACCESS;
                    nxt_pslverr   = !hit_any || bad_dir;
                end else begin
                    nxt_bus_state = AFC_BUS_IDLE;
                end
            end
            default: begin
                nxt_bus_state = AFC_BUS_IDLE;
                nxt_pslverr   = 1'b0;
            end
        endcase
    end

    assign pready  = (bus_state_ff == AFC_BUS_ACCESS) && psel && penable;
    assign pslverr = pready && pslverr_ff;
    assign prdata  = prdata_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_ff <= AFC_BUS_IDLE;
        end else begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    // Error decided at setup, shown only alongside pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_ff <= 1'b0;
        end else begin
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Read data captured at setup, held until the next setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= setup_ph ? nxt_prdata : prdata_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and interrupt registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_cfg_ff <= `AFC_ALARM_CFG_RST;
        end else begin
            alarm_cfg_ff <= nxt_alarm_cfg;
        end
    end

    // Set on a rising source edge; a same-cycle clear loses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= `AFC_IRQ_RST;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    // Interrupt enables share the status layout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_ff <= `AFC_IRQ_RST;
        end else begin
            irq_en_ff <= nxt_irq_en;
        end
    end

    // Last source levels, for rising-edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_ff <= `AFC_IRQ_RST;
        end else begin
            src_prev_ff <= src_vec;
        end
    end

    // Pin idles driven high: open-drain is off at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= '{value: 1'b1, oe_n: 1'b0};
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    // Shutdown request, one cycle behind the fault
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsd_ff <= 1'b0;
        end else begin
            tsd_ff <= nxt_tsd;
        end
    end

    assign fault_pin_n      = pin_ff;
    assign thermal_shutdown = tsd_ff;
    assign bg_crc_enable    =
        alarm_cfg_ff[`AFC_BIT_BG_CRC_EN];
    assign irq              = |(irq_stat_ff & irq_en_ff);

    ////////////////////////////////////////////////////////////////////////
    // Output filter select, one register per channel

    genvar ch;
    generate
        for (ch = 0; ch < NUM_FILT_CH; ch++) begin : g_filt
            assign wr_filt[ch] = wr_ok && addr_hi_zero &&
                afc_hit(reg_idx, 8'(`AFC_IDX_FILT_CH0 + ch));
            // Only the low field stores; upper bits read zero
            wire logic [FILT_W-1:0] nxt_filt =
                wr_filt[ch] ? pwdata[FILT_W-1:0] : filt_ff[ch];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt_ff[ch] <= FILT_W'(`AFC_FILT_RST);
                end else begin
                    filt_ff[ch] <= nxt_filt;
                end
            end

            assign filter_code_reserved[ch] =
                !afc_filt_valid(filt_ff[ch]);
        end
    endgenerate

    // Resistor select feeds the RC filter on damping_cap_pin_ch0
    assign filter_res_sel_ch0 = filt_ff[0];
    assign filter_res_sel_ch1 = filt_ff[1];

endmodule
`default_nettype wire

/* File: afc_top_sva.sv */
// Port checker for the fault configuration block
`timescale 1ns/1ns
`default_nettype none
module afc_top_chk
    import afc_pkg::*;
#(
    parameter int NUM_FILT_CH = 2,
    parameter int FILT_W      = 4
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic                 pready,
    input wire logic [31:0]          prdata,
    input wire logic                 pslverr,
    input wire afc_fault_type        fault_src,
    input wire afc_pin_type          fault_pin_n,
    input wire logic                 bg_crc_enable,
    input wire logic                 thermal_shutdown,
    input wire logic [FILT_W-1:0]    filter_res_sel_ch0,
    input wire logic [FILT_W-1:0]    filter_res_sel_ch1,
    input wire logic [NUM_FILT_CH-1:0] filter_code_reserved,
    input wire logic                 irq
);
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    wire commit  = psel & penable & pready & pwrite & pstrb[0];
    wire cfg_wr  = commit & (paddr == 32'h70);
    wire c0_wr   = commit & (paddr == 32'h74);
    wire alarm   = |(fault_src & ~cfg_ff[7:3]);
    // Released pad reads high through the pull-up
    wire pin_lvl = fault_pin_n.oe_n | fault_pin_n.value;
    assign nxt_cfg = cfg_wr ? pwdata[7:0] : cfg_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cfg_ff <= 8'h06;
        else cfg_ff <= nxt_cfg;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_pin; 1 |=> (pin_lvl == !$past(alarm)); endproperty
    a_pin: assert property (p_pin)
        else $error("fault pin level wrong");
    property p_od;
        1 |=> ($past(cfg_ff[0]) ? (fault_pin_n.value == 1'b0)
                                : (fault_pin_n.oe_n == 1'b0));
    endproperty
    a_od: assert property (p_od)
        else $error("pin drive mode wrong");
    property p_tsd;
        1 |=> (thermal_shutdown ==
               $past(cfg_ff[1] & fault_src.over_temp_fault));
    endproperty
    a_tsd: assert property (p_tsd)
        else $error("shutdown wrong");
    property p_crc; bg_crc_enable == cfg_ff[2]; endproperty
    a_crc: assert property (p_crc)
        else $error("crc enable wrong");
    property p_filt;
        c0_wr |=> (filter_res_sel_ch0 == $past(pwdata[FILT_W-1:0]));
    endproperty
    a_filt: assert property (p_filt)
        else $error("filter code wrong");
    property p_rsv;
        filter_code_reserved[0] ==
            !(filter_res_sel_ch0 inside {4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9});
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved flag wrong");
    property p_rd;
        pready & !pwrite & (paddr == 32'h70) |-> prdata == {24'h0, cfg_ff};
    endproperty
    a_rd: assert property (p_rd)
        else $error("config readback wrong");
    property p_rdy;
        (psel & !penable) ##1 (psel & penable) |-> pready;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("no zero-wait ready");
    c_od: cover property (cfg_ff[0] && !pin_lvl);
    c_tsd: cover property (thermal_shutdown);
    c_rsv: cover property (|filter_code_reserved);
endmodule
bind afc_top afc_top_chk #(.NUM_FILT_CH(NUM_FILT_CH), .FILT_W(FILT_W))
    afc_top_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fault_src(fault_src), .fault_pin_n(fault_pin_n),
    .bg_crc_enable(bg_crc_enable), .thermal_shutdown(thermal_shutdown),
    .filter_res_sel_ch0(filter_res_sel_ch0),
    .filter_res_sel_ch1(filter_res_sel_ch1),
    .filter_code_reserved(filter_code_reserved), .irq(irq));
`default_nettype wire

/* File: afc_host_model.sv */
// Host side of the fault pin: pull-up pad, alarm seen active low
`timescale 1ns/1ns
`default_nettype none
module afc_host_model
    import afc_pkg::*;
(
    input  wire afc_pin_type fault_pin_n,
    output logic             alarm_seen
);
    // Released pad floats to the pull-up level
    assign alarm_seen = ~(fault_pin_n.oe_n ? 1'b1
                                           : fault_pin_n.value);
endmodule
`default_nettype wire

/* File: tb_alarm_config_and_filter_select.sv */
// Self-checking bench for the fault configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_alarm_config_and_filter_select
    import afc_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, err;
    logic          pready, pslverr, bg_crc_enable, thermal_shutdown, irq;
    logic          alarm_seen;
    logic [31:0]   paddr, pwdata, prdata, rd;
    logic [3:0]    f0, f1, pstrb;
    logic [1:0]    frsv;
    afc_fault_type fault_src;
    afc_pin_type   fault_pin_n;
    int            n_errors, compares, cyc;
    afc_top afc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .fault_src(fault_src), .fault_pin_n(fault_pin_n),
        .bg_crc_enable(bg_crc_enable), .thermal_shutdown(thermal_shutdown),
        .filter_res_sel_ch0(f0), .filter_res_sel_ch1(f1),
        .filter_code_reserved(frsv), .irq(irq));
    afc_host_model afc_host_model_inst (.fault_pin_n(fault_pin_n),
        .alarm_seen(alarm_seen));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({irq, thermal_shutdown, pready, pslverr}, 4'h0);
        apb(1'b0, 32'h70, 32'h0);
        check(rd, 32'h06);
        apb(1'b0, 32'h74, 32'h0);
        check(rd, 32'h0);
        check(bg_crc_enable, 1'b1);
        check(alarm_seen, 1'b0);
        pstrb <= 4'he;
        apb(1'b1, 32'h70, 32'hff);
        pstrb <= 4'hf;
        check(err, 1'b0);
        apb(1'b0, 32'h70, 32'h0);
        check(rd, 32'h06);
    endtask
    task automatic t_rereset();
        apb(1'b1, 32'h70, 32'hfb);
        apb(1'b1, 32'h74, 32'h05);
        apb(1'b1, 32'hc8, 32'h1f);
        check(bg_crc_enable, 1'b0);
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        check(fault_pin_n, 2'b10);
        check(bg_crc_enable, 1'b1);
        check({irq, thermal_shutdown, f0}, 6'h00);
        apb(1'b0, 32'h70, 32'h0);
        check(rd, 32'h06);
        apb(1'b0, 32'hc8, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_masks();
        for (int i = 0; i < 5; i++) begin
            for (int m = 1; m >= 0; m--) begin
                apb(1'b1, 32'h70, 32'h06 | (m << (i + 3)));
                fault_src <= afc_fault_type'(5'h01 << i);
                tick(2);
                check(alarm_seen, !m);
                apb(1'b0, 32'hc0, 32'h0);
                check(rd, 32'h1 << i);
                fault_src <= '0;
                apb(1'b1, 32'hc4, 32'h1f);
            end
        end
    endtask
    task automatic t_drive();
        apb(1'b1, 32'h70, 32'h05);
        fault_src <= afc_fault_type'(5'h02);
        tick(2);
        check(fault_pin_n, 2'b00);
        check(alarm_seen, 1'b1);
        check(thermal_shutdown, 1'b0);
        fault_src <= '0;
        tick(2);
        check(fault_pin_n, 2'b01);
        check(alarm_seen, 1'b0);
        apb(1'b1, 32'h70, 32'h02);
        fault_src <= afc_fault_type'(5'h02);
        tick(2);
        check(thermal_shutdown, 1'b1);
        check(bg_crc_enable, 1'b0);
        fault_src <= '0;
        tick(2);
        check(fault_pin_n, 2'b10);
        check(thermal_shutdown, 1'b0);
        apb(1'b1, 32'h70, 32'h06);
        apb(1'b1, 32'hc4, 32'h1f);
    endtask
    task automatic t_filter();
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 32'h74, 32'hf0 | c);
            apb(1'b0, 32'h74, 32'h0);
            check(rd, c);
            check(f0, c);
            check(frsv[0], !(c inside {0, 5, 6, 7, 8, 9}));
        end
        apb(1'b1, 32'h78, 32'hf9);
        apb(1'b0, 32'h78, 32'h0);
        check(rd, 32'h9);
        check({frsv[1], f1}, 5'h09);
    endtask
    task automatic t_irq();
        apb(1'b1, 32'hc8, 32'h10);
        fault_src <= afc_fault_type'(5'h10);
        tick(2);
        check(irq, 1'b1);
        apb(1'b1, 32'hc8, 32'h0);
        tick(1);
        check(irq, 1'b0);
        apb(1'b1, 32'hc8, 32'h10);
        tick(1);
        check(irq, 1'b1);
        apb(1'b1, 32'hc4, 32'h10);
        tick(1);
        check(irq, 1'b0);
        fault_src <= '0;
        apb(1'b0, 32'hc4, 32'h0);
        check(err, 1'b1);
        apb(1'b0, 32'h100, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 32'hc0, 32'h1f);
        check(err, 1'b1);
        apb(1'b0, 32'hc0, 32'h0);
        check(rd, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            $display("ERROR %0t: run timed out", $time);
            tally_and_finish();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        fault_src = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_masks();
        t_drive();
        t_filter();
        t_irq();
        t_rereset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
